// file: src/uercc_pkg.sv
package uercc_pkg;
	// Register offsets of this block
	localparam logic [3:0] ADDR_DIV_LOW = 4'h0;
	localparam logic [3:0] ADDR_DIV_HIGH = 4'h1;
	localparam logic [3:0] ADDR_EFR = 4'h2;
	localparam logic [3:0] ADDR_IER = 4'h3;
	localparam logic [3:0] ADDR_FCR = 4'h4;
	localparam logic [3:0] ADDR_MCR = 4'h5;
	localparam logic [3:0] ADDR_LCR = 4'h6;
	localparam logic [3:0] ADDR_TRIG = 4'h7;
	localparam logic [3:0] ADDR_XFC = 4'h8;
	localparam logic [3:0] ADDR_STOP2 = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'ha;
	localparam logic [3:0] ADDR_RXCTL = 4'hb;
	// Reset values
	localparam logic [7:0] RESET_DIV_LOW = 8'h01;
	localparam logic [7:0] RESET_DIV_HIGH = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Field positions
	localparam int EFR_CTS_BIT = 7;
	localparam int EFR_RTS_BIT = 6;
	localparam int EFR_SPECIAL_BIT = 5;
	localparam int EFR_ENH_BIT = 4;
	localparam int IER_SLEEP_BIT = 4;
	localparam int IER_LINE_BIT = 2;
	localparam int MCR_RTS_BIT = 1;
	localparam int XFC_MULTIDROP_BIT = 0;
	localparam int XFC_AUTO_DIR_BIT = 4;
	localparam int XFC_INVERT_BIT = 5;
	localparam logic [7:0] IER_ENH_MASK = 8'hf0;
	localparam logic [7:0] FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] MCR_ENH_MASK = 8'he0;
	localparam logic [2:0] LCR_FORCE_ZERO = 3'h7;
	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uercc_bus_type;
	// One received 9-bit character
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic ninth;
	} uercc_char_type;
	// Character going to the receive FIFO
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic parity_error;
	} uercc_push_type;
endpackage : uercc_pkg

// file: src/uercc_core.sv
`timescale 1ns/1ps
module uercc_core (
	input wire logic clk,
	input wire logic reset_n,
	input wire uercc_pkg::uercc_bus_type bus,
	output logic [7:0] rdata,
	input wire logic cts_pin,
	input wire logic [3:0] rx_fifo_level,
	input wire logic tx_fifo_write,
	input wire logic tx_busy,
	input wire uercc_pkg::uercc_char_type rx_char,
	output uercc_pkg::uercc_push_type rx_push,
	output logic rts_pin,
	output logic tx_stop,
	output logic baud_tick,
	output logic special_detect,
	output logic line_irq,
	output logic [3:0] sw_flow_mode
);
	import uercc_pkg::*;

	logic [7:0] div_low_reg, div_low_next, div_high_reg, div_high_next;
	logic [7:0] efr_reg, efr_next, ier_reg, ier_next, fcr_reg, fcr_next;
	logic [7:0] mcr_reg, mcr_next, lcr_reg, lcr_next, trig_reg, trig_next;
	logic [7:0] xfc_reg, xfc_next, stop2_reg, stop2_next, rdata_reg, rdata_next;
	logic [15:0] baud_cnt_reg, baud_cnt_next;
	logic tick_reg, tick_next, flow_rts_reg, flow_rts_next;
	logic pending_reg, pending_next, rx_en_reg, rx_en_next;
	logic special_reg, special_next, irq_reg, irq_next;
	logic cts_meta_reg, cts_sync_reg, stop_reg, stop_next;
	uercc_push_type push_reg, push_next;
	logic [15:0] divisor;
	logic rx_en_set, rx_en_clr, match, auto_mode, dir_level;

	// Clear-to-send pin synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cts_meta_reg <= 1'b1;
			cts_sync_reg <= 1'b1;
		end else begin
			cts_meta_reg <= cts_pin;
			cts_sync_reg <= cts_meta_reg;
		end
	end

	assign divisor = {div_high_reg, div_low_reg};
	assign match = rx_char.data == stop2_reg;
	assign auto_mode = xfc_reg[XFC_MULTIDROP_BIT] && efr_reg[EFR_SPECIAL_BIT];

	// Register writes; enhanced bits keep old value unless unlocked
	always_comb begin
		div_low_next = div_low_reg;
		div_high_next = div_high_reg;
		efr_next = efr_reg;
		ier_next = ier_reg;
		fcr_next = fcr_reg;
		mcr_next = mcr_reg;
		lcr_next = lcr_reg;
		trig_next = trig_reg;
		xfc_next = xfc_reg;
		stop2_next = stop2_reg;
		if (bus.wr) begin
			case (bus.addr)
				ADDR_DIV_LOW: div_low_next = bus.wdata;
				ADDR_DIV_HIGH: div_high_next = bus.wdata;
				ADDR_EFR: efr_next = bus.wdata;
				ADDR_IER: begin
					ier_next = efr_reg[EFR_ENH_BIT] ? bus.wdata :
						((bus.wdata & ~IER_ENH_MASK) | (ier_reg & IER_ENH_MASK));
				end
				ADDR_FCR: begin
					fcr_next = efr_reg[EFR_ENH_BIT] ? bus.wdata :
						((bus.wdata & ~FCR_ENH_MASK) | (fcr_reg & FCR_ENH_MASK));
				end
				ADDR_MCR: begin
					mcr_next = efr_reg[EFR_ENH_BIT] ? bus.wdata :
						((bus.wdata & ~MCR_ENH_MASK) | (mcr_reg & MCR_ENH_MASK));
				end
				ADDR_LCR: lcr_next = bus.wdata;
				ADDR_TRIG: trig_next = bus.wdata;
				ADDR_XFC: xfc_next = bus.wdata;
				ADDR_STOP2: stop2_next = bus.wdata;
				default: ;
			endcase
		end
	end

	// Read mux, data valid the cycle after the strobe
	always_comb begin
		rdata_next = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				ADDR_DIV_LOW: rdata_next = div_low_reg;
				ADDR_DIV_HIGH: rdata_next = div_high_reg;
				ADDR_EFR: rdata_next = efr_reg;
				ADDR_IER: rdata_next = ier_reg;
				ADDR_FCR: rdata_next = fcr_reg;
				ADDR_MCR: rdata_next = mcr_reg;
				ADDR_LCR: rdata_next = lcr_reg;
				ADDR_TRIG: rdata_next = trig_reg;
				ADDR_XFC: rdata_next = xfc_reg;
				ADDR_STOP2: rdata_next = stop2_reg;
				ADDR_STATUS: rdata_next = {4'h0, rts_pin, cts_sync_reg, special_reg, rx_en_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// Baud divider, restarts on a divisor write
	always_comb begin
		baud_cnt_next = baud_cnt_reg + 16'h0001;
		tick_next = 1'b0;
		if (bus.wr && (bus.addr == ADDR_DIV_LOW || bus.addr == ADDR_DIV_HIGH)) begin
			baud_cnt_next = 16'h0000;
		end else if (divisor != 16'h0000 && baud_cnt_reg >= divisor - 16'h0001) begin
			baud_cnt_next = 16'h0000;
			tick_next = 1'b1;
		end
	end

	// Hardware flow and auto direction control of RTS
	always_comb begin
		flow_rts_next = flow_rts_reg;
		if (rx_fifo_level >= trig_reg[3:0]) begin
			flow_rts_next = 1'b1;
		end else if (rx_fifo_level <= trig_reg[7:4]) begin
			flow_rts_next = 1'b0;
		end
		pending_next = pending_reg;
		if (tx_fifo_write) begin
			pending_next = 1'b1;
		end else if (!tx_busy) begin
			pending_next = 1'b0;
		end
		stop_next = efr_reg[EFR_CTS_BIT] && cts_sync_reg;
	end

	assign dir_level = pending_reg ^ ~xfc_reg[XFC_INVERT_BIT];

	// RTS source select: auto direction beats flow circuit beats modem bit
	always_comb begin
		if (xfc_reg[XFC_AUTO_DIR_BIT]) begin
			rts_pin = dir_level;
		end else if (efr_reg[EFR_RTS_BIT]) begin
			rts_pin = flow_rts_reg;
		end else begin
			rts_pin = ~mcr_reg[MCR_RTS_BIT];
		end
	end

	// Receive filter for multidrop and special detect
	always_comb begin
		push_next = '0;
		special_next = special_reg;
		irq_next = 1'b0;
		rx_en_set = 1'b0;
		rx_en_clr = 1'b0;
		if (bus.rd && bus.addr == ADDR_STATUS) begin
			special_next = 1'b0;
		end
		if (rx_char.valid) begin
			if (efr_reg[EFR_SPECIAL_BIT] && match) begin
				special_next = 1'b1;
			end
			if (!xfc_reg[XFC_MULTIDROP_BIT]) begin
				push_next = '{1'b1, rx_char.data, 1'b0};
			end else if (auto_mode) begin
				if (rx_char.ninth && match) begin
					push_next = '{1'b1, rx_char.data, rx_char.ninth};
					rx_en_set = 1'b1;
					irq_next = ier_reg[IER_LINE_BIT];
				end else if (rx_char.ninth) begin
					rx_en_clr = 1'b1;
				end else if (rx_en_reg) begin
					push_next = '{1'b1, rx_char.data, 1'b0};
				end
			end else if (rx_char.ninth) begin
				push_next = '{1'b1, rx_char.data, 1'b1};
				irq_next = ier_reg[IER_LINE_BIT];
			end else if (rx_en_reg) begin
				push_next = '{1'b1, rx_char.data, 1'b0};
			end
		end
		// Software receiver control; hardware set wins over clear
		rx_en_next = rx_en_reg;
		if (bus.wr && bus.addr == ADDR_RXCTL) begin
			rx_en_next = bus.wdata[0];
		end
		if (rx_en_clr) begin
			rx_en_next = 1'b0;
		end
		if (rx_en_set) begin
			rx_en_next = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_low_reg <= RESET_DIV_LOW;
			div_high_reg <= RESET_DIV_HIGH;
			efr_reg <= RESET_BYTE;
			ier_reg <= RESET_BYTE;
			fcr_reg <= RESET_BYTE;
			mcr_reg <= RESET_BYTE;
			lcr_reg <= RESET_BYTE;
			trig_reg <= RESET_BYTE;
			xfc_reg <= RESET_BYTE;
			stop2_reg <= RESET_BYTE;
			rdata_reg <= RESET_BYTE;
			baud_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
			flow_rts_reg <= 1'b0;
			pending_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			special_reg <= 1'b0;
			irq_reg <= 1'b0;
			stop_reg <= 1'b0;
			push_reg <= '0;
		end else begin
			div_low_reg <= div_low_next;
			div_high_reg <= div_high_next;
			efr_reg <= efr_next;
			ier_reg <= ier_next;
			fcr_reg <= fcr_next;
			mcr_reg <= mcr_next;
			lcr_reg <= lcr_next;
			trig_reg <= trig_next;
			xfc_reg <= xfc_next;
			stop2_reg <= stop2_next;
			rdata_reg <= rdata_next;
			baud_cnt_reg <= baud_cnt_next;
			tick_reg <= tick_next;
			flow_rts_reg <= flow_rts_next;
			pending_reg <= pending_next;
			rx_en_reg <= rx_en_next;
			special_reg <= special_next;
			irq_reg <= irq_next;
			stop_reg <= stop_next;
			push_reg <= push_next;
		end
	end

	assign rdata = rdata_reg;
	assign rx_push = push_reg;
	assign tx_stop = stop_reg;
	assign baud_tick = tick_reg;
	assign special_detect = special_reg;
	assign line_irq = irq_reg;
	assign sw_flow_mode = efr_reg[3:0];

	// Checks
	AST_ENH_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
		(bus.wr && bus.addr == ADDR_IER && !efr_reg[EFR_ENH_BIT])
		|=> ier_reg[7:4] == $past(ier_reg[7:4])) else $error("INTERRUPT_ENABLE_REG locked bits changed");
	AST_CTS_STOP: assert property (@(posedge clk) disable iff (!reset_n)
		(efr_reg[EFR_CTS_BIT] && cts_sync_reg) |=> tx_stop) else $error("CTS not honoured");
	AST_DROP_DATA: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_char.valid && xfc_reg[0] && !rx_char.ninth && !rx_en_reg) |=> !rx_push.valid)
		else $error("Data kept while receiver off");
	AST_ADDR_PE: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_char.valid && xfc_reg[0] && !efr_reg[5] && rx_char.ninth)
		|=> rx_push.valid && rx_push.parity_error) else $error("Address not flagged");
	AST_AUTO_EN: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_char.valid && auto_mode && rx_char.ninth && match) |=> rx_en_reg && rx_push.valid)
		else $error("Match did not enable receiver");
	AST_AUTO_DIS: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_char.valid && auto_mode && rx_char.ninth && !match && !rx_en_set)
		|=> !rx_en_reg && !rx_push.valid) else $error("Mismatch not dropped");
	AST_DIR: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_fifo_write && xfc_reg[4] && !xfc_reg[5] && $stable(xfc_reg)) |=> !rts_pin)
		else $error("RTS not asserted on write");
	AST_TICK: assert property (@(posedge clk) disable iff (!reset_n)
		tick_reg |-> baud_cnt_reg == 16'h0000) else $error("Tick off count");
	COV_AUTO: cover property (@(posedge clk) disable iff (!reset_n) rx_en_set);
	COV_SPECIAL: cover property (@(posedge clk) disable iff (!reset_n) $rose(special_reg));
	COV_TICK: cover property (@(posedge clk) disable iff (!reset_n) tick_reg);
endmodule : uercc_core

// file: testbench/uercc_station.sv
`timescale 1ns/1ps
module uercc_station (
	input wire logic clk,
	output uercc_pkg::uercc_char_type rx_char,
	output logic cts_pin
);
	import uercc_pkg::*;
	// Line quiet and remote ready at start
	initial begin
		rx_char = '0;
		cts_pin = 1'b0;
	end
	// One 9-bit character for one cycle, then the lines go to inverted junk
	task automatic send(input logic [7:0] d, input logic n);
		@(posedge clk);
		rx_char <= {1'b1, d, n};
		@(posedge clk);
		rx_char <= {1'b0, ~d, ~n};
	endtask : send
	// Remote holds us off (high) or lets us go on (low)
	task automatic hold_off(input logic h);
		@(posedge clk);
		cts_pin <= h;
	endtask : hold_off
endmodule : uercc_station

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import uercc_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	uercc_bus_type bus = '0;
	logic [3:0] rx_fifo_level = 4'h0;
	logic tx_fifo_write = 1'b0;
	logic tx_busy = 1'b0;
	uercc_char_type rx_char;
	uercc_push_type rx_push;
	logic cts_pin, rts_pin, tx_stop, baud_tick, special_detect, line_irq;
	logic [7:0] rdata;
	logic [3:0] sw_flow_mode;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	uercc_core u_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.cts_pin(cts_pin), .rx_fifo_level(rx_fifo_level), .tx_fifo_write(tx_fifo_write),
		.tx_busy(tx_busy), .rx_char(rx_char), .rx_push(rx_push), .rts_pin(rts_pin),
		.tx_stop(tx_stop), .baud_tick(baud_tick), .special_detect(special_detect),
		.line_irq(line_irq), .sw_flow_mode(sw_flow_mode));
	uercc_station u_station (.clk(clk), .rx_char(rx_char), .cts_pin(cts_pin));
	// Verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Register bus cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= {a, d, 2'b10};
		@(posedge clk);
		bus <= '0;
	endtask : wr
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= {a, 8'h00, 2'b01};
		@(posedge clk);
		bus <= '0;
		#1 chk("read data", rdata, exp);
	endtask : rchk
	// Wait some cycles then look at settled outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	// Cycles from one baud tick to the next, settled samples only
	task automatic tick_gap(output int n);
		settle(1);
		for (n = 0; n < 300 && baud_tick !== 1'b1; n++) settle(1);
		n = 1;
		settle(1);
		while (baud_tick !== 1'b1 && n < 300) begin
			n++;
			settle(1);
		end
	endtask : tick_gap
	// One character in, push and interrupt judged one cycle later
	task automatic rx(input logic [7:0] d, input logic n, input logic ev, input logic epe);
		u_station.send(d, n);
		#1 chk("push", {rx_push.valid, line_irq, ev ? {rx_push.data, rx_push.parity_error} : 9'h0},
			{ev, epe, ev ? {d, epe} : 9'h0});
	endtask : rx
	task automatic t_reset();
		rchk(ADDR_DIV_LOW, RESET_DIV_LOW);
		rchk(ADDR_DIV_HIGH, RESET_DIV_HIGH);
		rchk(ADDR_EFR, RESET_BYTE);
		chk("rts", rts_pin, 1'b1);
		wr(4'hf, 8'hff);
		rchk(4'hf, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_divisor();
		int n;
		wr(ADDR_DIV_LOW, 8'h03);
		tick_gap(n);
		chk("tick spacing", n, 3);
		wr(ADDR_DIV_HIGH, 8'h01);
		tick_gap(n);
		chk("tick spacing", n, 259);
		rchk(ADDR_DIV_HIGH, 8'h01);
		rchk(ADDR_DIV_LOW, 8'h03);
		$display("divisor test done");
	endtask : t_divisor
	task automatic t_enhanced();
		wr(ADDR_IER, 8'hf4);
		wr(ADDR_FCR, 8'h30);
		wr(ADDR_MCR, 8'he0);
		rchk(ADDR_IER, 8'h04);
		rchk(ADDR_MCR, 8'h00);
		rchk(ADDR_FCR, 8'h00);
		wr(ADDR_EFR, 8'h1a);
		rchk(ADDR_EFR, 8'h1a);
		chk("sw flow", sw_flow_mode, 4'ha);
		wr(ADDR_IER, 8'he4);
		wr(ADDR_FCR, 8'h30);
		wr(ADDR_MCR, 8'he0);
		rchk(ADDR_IER, 8'he4);
		rchk(ADDR_FCR, 8'h30);
		rchk(ADDR_MCR, 8'he0);
		wr(ADDR_IER, 8'h04);
		wr(ADDR_MCR, 8'h00);
		$display("enhanced test done");
	endtask : t_enhanced
	task automatic t_cts();
		wr(ADDR_EFR, 8'h90);
		u_station.hold_off(1'b1);
		settle(4);
		chk("tx stop", tx_stop, 1'b1);
		u_station.hold_off(1'b0);
		settle(4);
		chk("tx stop", tx_stop, 1'b0);
		u_station.hold_off(1'b1);
		wr(ADDR_EFR, 8'h10);
		settle(4);
		chk("tx stop", tx_stop, 1'b0);
		u_station.hold_off(1'b0);
		$display("cts test done");
	endtask : t_cts
	task automatic t_flow_rts();
		wr(ADDR_TRIG, 8'h28);
		wr(ADDR_MCR, 8'h02);
		wr(ADDR_EFR, 8'h50);
		rx_fifo_level <= 4'h8;
		settle(3);
		chk("rts", rts_pin, 1'b1);
		rx_fifo_level <= 4'h5;
		settle(3);
		chk("rts", rts_pin, 1'b1);
		rx_fifo_level <= 4'h2;
		settle(3);
		chk("rts", rts_pin, 1'b0);
		rx_fifo_level <= 4'h5;
		settle(3);
		chk("rts", rts_pin, 1'b0);
		rx_fifo_level <= 4'h8;
		wr(ADDR_EFR, 8'h10);
		settle(3);
		chk("rts", rts_pin, 1'b0);
		$display("flow rts test done");
	endtask : t_flow_rts
	// Hardware flow is off here; mcr bit1 set would give low without auto direction
	task automatic t_dir(input logic inv);
		wr(ADDR_XFC, {2'b00, inv, 5'h10});
		settle(1);
		chk("rts idle", rts_pin, !inv);
		@(posedge clk);
		tx_fifo_write <= 1'b1;
		tx_busy <= 1'b1;
		@(posedge clk);
		tx_fifo_write <= 1'b0;
		settle(2);
		chk("rts pending", rts_pin, inv);
		@(posedge clk);
		tx_busy <= 1'b0;
		settle(3);
		chk("rts done", rts_pin, !inv);
		$display("direction test done");
	endtask : t_dir
	task automatic t_plain();
		wr(ADDR_XFC, 8'h00);
		wr(ADDR_STOP2, 8'h42);
		wr(ADDR_EFR, 8'h30);
		rx(8'h42, 1'b1, 1'b1, 1'b0);
		settle(1);
		chk("special", special_detect, 1'b1);
		rx(8'h55, 1'b0, 1'b1, 1'b0);
		rchk(ADDR_STATUS, 8'h02);
		chk("special", special_detect, 1'b0);
		$display("plain rx test done");
	endtask : t_plain
	task automatic t_normal_md();
		wr(ADDR_EFR, 8'h10);
		wr(ADDR_XFC, 8'h01);
		wr(ADDR_LCR, 8'h38);
		wr(ADDR_RXCTL, 8'h00);
		rx(8'h11, 1'b0, 1'b0, 1'b0);
		rx(8'h22, 1'b1, 1'b1, 1'b1);
		wr(ADDR_RXCTL, 8'h01);
		rx(8'h33, 1'b0, 1'b1, 1'b0);
		rx(8'h44, 1'b1, 1'b1, 1'b1);
		wr(ADDR_RXCTL, 8'h00);
		$display("normal multidrop test done");
	endtask : t_normal_md
	task automatic t_auto_md();
		wr(ADDR_EFR, 8'h30);
		rx(8'h11, 1'b0, 1'b0, 1'b0);
		rx(8'h41, 1'b1, 1'b0, 1'b0);
		rx(8'h42, 1'b1, 1'b1, 1'b1);
		rx(8'h55, 1'b0, 1'b1, 1'b0);
		rx(8'h42, 1'b1, 1'b1, 1'b1);
		rx(8'h43, 1'b1, 1'b0, 1'b0);
		rx(8'h56, 1'b0, 1'b0, 1'b0);
		$display("auto address test done");
	endtask : t_auto_md
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_divisor();
		t_enhanced();
		t_cts();
		t_flow_rts();
		t_dir(1'b0);
		t_dir(1'b1);
		t_plain();
		t_normal_md();
		t_auto_md();
		report_and_stop();
	end
endmodule : testbench
